// [inc/lock_cfg.svh]
// Constants for the security lock block
`ifndef LOCK_CFG_SVH
`define LOCK_CFG_SVH
`define LOCK_KEY_BITS 32
`define LOCK_VOTE_MIN 28
`define LOCK_VOTE_CNT_W 6
`define LOCK_PROT_W 2
`define LOCK_BLK_IDX_W 4
`define LOCK_PROT_OPEN 2'h0
`define LOCK_PROT_VERIFY_MAX 2'h1
`define LOCK_KEY_RESET 32'h0000_0000
`define LOCK_DATA_RESET 32'h0000_0000
`endif

// [inc/lock_pkg.sv]
// Types shared by the security lock block
`include "lock_cfg.svh"
package lock_pkg;
    typedef enum logic [3:0] {
        OP_LOAD_KEY,
        OP_COMMIT_KEY,
        OP_READ_LATCH,
        OP_ERASE_ALL,
        OP_PROG_ALL,
        OP_VERIFY_ALL,
        OP_ERASE_BLK,
        OP_PROG_BLK,
        OP_VERIFY_BLK,
        OP_SET_PROT
    } cmd_op_t;
    typedef enum logic {PORT_JTAG, PORT_SWD} dbg_port_t;
    typedef enum logic [1:0] {RSP_OK, RSP_REJECT, RSP_FAIL} rsp_status_t;
    typedef struct packed {
        cmd_op_t op;
        dbg_port_t port;
        logic [`LOCK_BLK_IDX_W-1:0] blk;
        logic [`LOCK_PROT_W-1:0] level;
        logic [`LOCK_KEY_BITS-1:0] data;
    } cmd_t;
    typedef struct packed {
        rsp_status_t status;
        logic [`LOCK_KEY_BITS-1:0] data;
    } rsp_t;
endpackage

// [rtl/pin_sync3.sv]
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module pin_sync3
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic pin,
    output logic q
);
    logic s1_r, s2_r, s3_r, q_r;
    logic q_nxt;

    // Output follows only once the last two stages agree
    always_comb
    begin
        q_nxt = (s2_r == s3_r) ? s3_r : q_r;
    end

    // First stage feeds the second stage only
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
            q_r <= 1'b0;
        end
        else
        begin
            s1_r <= pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
            q_r <= q_nxt;
        end
    end

    assign q = q_r;
endmodule
`default_nettype wire

// [rtl/key_vote.sv]
// Super-majority comparison of latch cells against the key
`timescale 1ns/100ps
`default_nettype none
`include "lock_cfg.svh"
module key_vote
#(
    parameter int W = `LOCK_KEY_BITS,
    parameter int MIN = `LOCK_VOTE_MIN,
    parameter logic [W-1:0] KEY = '0
)
(
    input wire logic [W-1:0] cells,
    output logic match
);
    logic [W-1:0] agree;
    logic [`LOCK_VOTE_CNT_W-1:0] cnt;

    // Refuse a threshold or width that the vote counter cannot serve
    if (MIN < 1 || MIN > W || W >= (1 << `LOCK_VOTE_CNT_W))
    begin : g_bad_cfg
        $error("key_vote: threshold or width out of range");
    end

    // One agreement bit per cell
    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_bit
            assign agree[i] = ~(cells[i] ^ KEY[i]);
        end
    endgenerate

    // Count agreeing cells; a few failed cells do not drop the lock
    always_comb
    begin
        cnt = '0;
        for (int k = 0; k < W; k++)
            cnt = cnt + {{(`LOCK_VOTE_CNT_W-1){1'b0}}, agree[k]};
        match = (cnt >= `LOCK_VOTE_CNT_W'(MIN));
    end
endmodule
`default_nettype wire

// [rtl/security_lock.sv]
// Device security lock and external flash access gate
// Summary of operation
// - Lock output asserts when at least 28 of 32 latch bits match the key.
// - Locking needs key loaded, committed to nonvolatile cells, then a reset.
// - Lock output is sampled only around reset and decides external access.
// - When locked, debug, test, programming ports stay disabled.
// - While lock output asserts, commits that alter the latch are refused.
// - Key writes accepted only when no flash protection level is set.
// - After committing the key, access continues until the next reset.
// - Protection levels only rise; full device erase alone clears them.
// - Whole-device erase, program and verify over JTAG or SWD.
// - Block erase, program, verify only when block protection allows.
// - Latch contents are readable over the SWD port.
`timescale 1ns/100ps
`default_nettype none
`include "lock_cfg.svh"
module security_lock
#(
    parameter int NBLK = 16,
    parameter logic [`LOCK_KEY_BITS-1:0] KEY = 32'h1234_abcd // Arbitrary value
)
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic [`LOCK_KEY_BITS-1:0] nv_cells,
    output logic [`LOCK_KEY_BITS-1:0] nv_prog_data,
    output logic nv_prog_req,
    input wire logic nv_prog_done,
    input wire logic [NBLK-1:0][`LOCK_PROT_W-1:0] prot_init,
    output logic [NBLK-1:0][`LOCK_PROT_W-1:0] prot_level,
    input wire logic cmd_valid,
    input wire lock_pkg::cmd_t cmd,
    output logic cmd_ready,
    output logic rsp_valid,
    output lock_pkg::rsp_t rsp,
    output logic fl_req,
    output lock_pkg::cmd_op_t fl_op,
    output logic [`LOCK_BLK_IDX_W-1:0] fl_blk,
    output logic [`LOCK_KEY_BITS-1:0] fl_data,
    input wire logic fl_done,
    input wire logic fl_ok,
    input wire logic test_pin,
    output logic jtag_en,
    output logic swd_en,
    output logic debug_en,
    output logic test_en,
    output logic locked
);
    import lock_pkg::*;

    typedef enum logic [1:0] {ST_INIT, ST_IDLE, ST_FLASH, ST_NVPROG} state_t;

    // Block index field must reach every block
    if (NBLK < 1 || NBLK > (1 << `LOCK_BLK_IDX_W))
    begin : g_bad_nblk
        $error("security_lock: NBLK out of range");
    end

    state_t state_r, state_nxt;
    logic locked_r, locked_nxt;
    logic [`LOCK_KEY_BITS-1:0] vol_key_r, vol_key_nxt;
    logic [NBLK-1:0][`LOCK_PROT_W-1:0] prot_r, prot_nxt;
    cmd_t cur_r, cur_nxt;
    logic rsp_valid_r, rsp_valid_nxt;
    rsp_t rsp_r, rsp_nxt;
    logic lock_live, test_sync, any_prot, take, blk_ok, perm;
    logic [`LOCK_PROT_W-1:0] blk_lvl;
    logic full_clr;

    key_vote #(.W(`LOCK_KEY_BITS), .MIN(`LOCK_VOTE_MIN), .KEY(KEY)) u_vote
    (
        .cells(nv_cells),
        .match(lock_live)
    );

    pin_sync3 u_test_sync
    (
        .clk(clk),
        .rstn(rstn),
        .pin(test_pin),
        .q(test_sync)
    );

    // Decode helpers for the command in front of us
    always_comb
    begin
        any_prot = 1'b0;
        for (int b = 0; b < NBLK; b++)
            any_prot = any_prot | (prot_r[b] != `LOCK_PROT_OPEN);
        blk_ok = (32'(cmd.blk) < NBLK);
        blk_lvl = blk_ok ? prot_r[cmd.blk] : `LOCK_PROT_OPEN;
        // Verify tolerates a low level; erase and program need an open block
        perm = (cmd.op == OP_VERIFY_BLK) ? (blk_lvl <= `LOCK_PROT_VERIFY_MAX)
                                         : (blk_lvl == `LOCK_PROT_OPEN);
        take = cmd_valid && cmd_ready;
    end

    // Command sequencer next state
    always_comb
    begin
        state_nxt = state_r;
        locked_nxt = locked_r;
        vol_key_nxt = vol_key_r;
        prot_nxt = prot_r;
        cur_nxt = cur_r;
        rsp_valid_nxt = 1'b0;
        rsp_nxt = rsp_r;
        case (state_r)
            ST_INIT:
            begin
                // First edge after reset release: the only place lock is taken
                locked_nxt = lock_live;
                prot_nxt = prot_init;
                state_nxt = ST_IDLE;
            end
            ST_IDLE:
            begin
                if (take)
                begin
                    rsp_valid_nxt = 1'b1;
                    rsp_nxt.status = RSP_REJECT;
                    rsp_nxt.data = `LOCK_DATA_RESET;
                    cur_nxt = cmd;
                    if (locked_r)
                    begin
                        // Identification read is the only thing left open
                        if (cmd.op == OP_READ_LATCH && cmd.port == PORT_SWD)
                        begin
                            rsp_nxt.status = RSP_OK;
                            rsp_nxt.data = nv_cells;
                        end
                    end
                    else
                    begin
                        case (cmd.op)
                            OP_LOAD_KEY:
                            begin
                                if (!any_prot)
                                begin
                                    vol_key_nxt = cmd.data;
                                    rsp_nxt.status = RSP_OK;
                                end
                            end
                            OP_COMMIT_KEY:
                            begin
                                // Live lock output gates off any rewrite
                                if (!any_prot && !lock_live)
                                begin
                                    rsp_valid_nxt = 1'b0;
                                    state_nxt = ST_NVPROG;
                                end
                            end
                            OP_READ_LATCH:
                            begin
                                if (cmd.port == PORT_SWD)
                                begin
                                    rsp_nxt.status = RSP_OK;
                                    rsp_nxt.data = nv_cells;
                                end
                            end
                            OP_ERASE_ALL, OP_PROG_ALL, OP_VERIFY_ALL:
                            begin
                                rsp_valid_nxt = 1'b0;
                                state_nxt = ST_FLASH;
                            end
                            OP_ERASE_BLK, OP_PROG_BLK, OP_VERIFY_BLK:
                            begin
                                if (blk_ok && perm)
                                begin
                                    rsp_valid_nxt = 1'b0;
                                    state_nxt = ST_FLASH;
                                end
                            end
                            OP_SET_PROT:
                            begin
                                if (blk_ok && cmd.level >= blk_lvl)
                                begin
                                    prot_nxt[cmd.blk] = cmd.level;
                                    rsp_nxt.status = RSP_OK;
                                end
                            end
                            default:
                            begin
                                rsp_nxt.status = RSP_REJECT;
                            end
                        endcase
                    end
                end
            end
            ST_FLASH:
            begin
                if (fl_done)
                begin
                    rsp_valid_nxt = 1'b1;
                    rsp_nxt.status = fl_ok ? RSP_OK : RSP_FAIL;
                    rsp_nxt.data = `LOCK_DATA_RESET;
                    // Protection falls only with a completed full erase
                    if (fl_ok && cur_r.op == OP_ERASE_ALL)
                        prot_nxt = '0;
                    state_nxt = ST_IDLE;
                end
            end
            ST_NVPROG:
            begin
                // Access stays granted after commit; lock waits for reset
                if (nv_prog_done)
                begin
                    rsp_valid_nxt = 1'b1;
                    rsp_nxt.status = RSP_OK;
                    rsp_nxt.data = vol_key_r;
                    state_nxt = ST_IDLE;
                end
            end
            default:
            begin
                state_nxt = ST_INIT;
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_r <= ST_INIT;
            locked_r <= 1'b1;
            vol_key_r <= `LOCK_KEY_RESET;
            prot_r <= '0;
            cur_r <= '0;
            rsp_valid_r <= 1'b0;
            rsp_r <= '0;
        end
        else
        begin
            state_r <= state_nxt;
            locked_r <= locked_nxt;
            vol_key_r <= vol_key_nxt;
            prot_r <= prot_nxt;
            cur_r <= cur_nxt;
            rsp_valid_r <= rsp_valid_nxt;
            rsp_r <= rsp_nxt;
        end
    end

    // Port gating; locked_r powers up set so nothing opens before sampling
    assign jtag_en = !locked_r;
    assign swd_en = !locked_r;
    assign debug_en = !locked_r;
    assign test_en = test_sync && !locked_r;
    assign locked = locked_r;
    assign cmd_ready = (state_r == ST_IDLE);
    assign rsp_valid = rsp_valid_r;
    assign rsp = rsp_r;
    assign fl_req = (state_r == ST_FLASH);
    assign fl_op = cur_r.op;
    assign fl_blk = cur_r.blk;
    assign fl_data = cur_r.data;
    assign nv_prog_req = (state_r == ST_NVPROG);
    assign nv_prog_data = vol_key_r;
    assign prot_level = prot_r;
    // Completed full erase, watched by the protection check
    assign full_clr = (state_r == ST_FLASH) && fl_done && fl_ok && (cur_r.op == OP_ERASE_ALL);

    // Checks on the lock and the access gate
    a_lock_only_reset: assert property (@(posedge clk) disable iff (!rstn)
        (state_r != ST_INIT) |=> $stable(locked_r))
        else $error("lock decision changed outside reset");
    a_ports_gated: assert property (@(posedge clk) disable iff (!rstn)
        locked_r |-> !jtag_en && !swd_en && !debug_en && !test_en)
        else $error("port enabled while locked");
    a_vote_exact: assert property (@(posedge clk) disable iff (!rstn)
        ($countones(nv_cells ~^ KEY) >= `LOCK_VOTE_MIN) |-> lock_live)
        else $error("vote missed a near match");
    a_vote_short: assert property (@(posedge clk) disable iff (!rstn)
        ($countones(nv_cells ~^ KEY) < `LOCK_VOTE_MIN) |-> !lock_live)
        else $error("vote passed below the threshold");
    a_commit_guard: assert property (@(posedge clk) disable iff (!rstn)
        $rose(nv_prog_req) |-> !$past(lock_live) && !$past(any_prot))
        else $error("latch commit while locked or protected");
    a_key_refused: assert property (@(posedge clk) disable iff (!rstn)
        (take && cmd.op == OP_LOAD_KEY && any_prot) |=> rsp_valid && rsp.status == RSP_REJECT
        ##1 $stable(vol_key_r))
        else $error("key load accepted with protection set");
    a_prot_clear: assert property (@(posedge clk) disable iff (!rstn)
        (state_r != ST_INIT && $fell(any_prot)) |-> $past(full_clr))
        else $error("protection cleared without full erase");
    a_blk_perm: assert property (@(posedge clk) disable iff (!rstn)
        (fl_req && (fl_op == OP_ERASE_BLK || fl_op == OP_PROG_BLK))
        |-> prot_r[fl_blk] == `LOCK_PROT_OPEN)
        else $error("block write issued on protected block");
    a_swd_read: assert property (@(posedge clk) disable iff (!rstn)
        (take && cmd.op == OP_READ_LATCH && cmd.port == PORT_JTAG)
        |=> rsp_valid && rsp.status == RSP_REJECT)
        else $error("latch read allowed over JTAG");
    a_flash_done: assert property (@(posedge clk) disable iff (!rstn)
        (fl_req && fl_done) |=> rsp_valid && cmd_ready && !fl_req)
        else $error("flash completion not answered");

    c_locked_boot: cover property (@(posedge clk) disable iff (!rstn)
        $fell(state_r == ST_INIT) && locked_r);
    c_full_erase: cover property (@(posedge clk) disable iff (!rstn)
        fl_req && fl_done && fl_ok && fl_op == OP_ERASE_ALL && any_prot);
    c_commit: cover property (@(posedge clk) disable iff (!rstn)
        nv_prog_req && nv_prog_done);
    c_blk_reject: cover property (@(posedge clk) disable iff (!rstn)
        take && cmd.op == OP_ERASE_BLK && !perm);
endmodule
`default_nettype wire

// [test/cell_model.sv]
// Latch cell macro and flash engine model for the security lock bench
`timescale 1ns/100ps
`default_nettype none
module cell_model
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic [31:0] nv_prog_data,
    input wire logic nv_prog_req,
    output logic [31:0] nv_cells,
    output logic nv_prog_done,
    input wire logic fl_req,
    output logic fl_done,
    output logic fl_ok,
    input wire logic [3:0] lat,
    input wire logic fail,
    input wire logic preset,
    input wire logic [31:0] preset_val
);
    logic [3:0] cnt_r;
    logic busy_r;

    // Cells have no reset: they must survive the chip reset like real storage
    always @(posedge clk)
        if (preset)
            nv_cells <= preset_val;
        else if (nv_prog_done)
            nv_cells <= nv_prog_data;

    // Answer after lat cycles; busy waits for the request to drop so one
    // request never earns two done pulses
    always @(posedge clk or negedge rstn)
        if (!rstn)
        begin
            cnt_r <= 4'h0;
            busy_r <= 1'b0;
            nv_prog_done <= 1'b0;
            fl_done <= 1'b0;
            fl_ok <= 1'b0;
        end
        else
        begin
            nv_prog_done <= 1'b0;
            fl_done <= 1'b0;
            fl_ok <= ~fl_ok; // Result is meaningless outside done
            if (busy_r)
                busy_r <= nv_prog_req | fl_req;
            else if ((nv_prog_req | fl_req) && cnt_r == lat)
            begin
                cnt_r <= 4'h0;
                busy_r <= 1'b1;
                nv_prog_done <= nv_prog_req;
                fl_done <= fl_req;
                fl_ok <= !fail;
            end
            else if (nv_prog_req | fl_req)
                cnt_r <= cnt_r + 4'h1;
        end
endmodule
`default_nettype wire

// [test/testbench.sv]
// Self-checking bench for the security lock block
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import lock_pkg::*;
    localparam int NB = 12;
    localparam logic [31:0] KEY = 32'h5a3c_96e1; // Arbitrary value
    typedef struct {rsp_status_t st; logic [31:0] d; bit ck;} note_t;
    logic clk = 0, rstn = 0, cmd_valid = 0, test_pin = 0, fail = 0, preset = 1;
    logic [31:0] preset_val = ~KEY;
    logic [3:0] lat = 4'h0;
    logic [NB-1:0][1:0] prot_init = '0;
    cmd_t cmd = '0;
    logic [31:0] nv_cells, nv_prog_data, fl_data;
    logic nv_prog_req, nv_prog_done, cmd_ready, rsp_valid, fl_req, fl_done, fl_ok;
    logic jtag_en, swd_en, debug_en, test_en, locked;
    logic [NB-1:0][1:0] prot_level;
    logic [3:0] fl_blk;
    cmd_op_t fl_op;
    rsp_t rsp;
    note_t q[$];
    note_t nt;
    int n_fail = 0, check_count = 0, seed = 83914, cyc = 0;

    always #5 clk = ~clk;

    security_lock #(.NBLK(NB), .KEY(KEY)) u_dut (.clk(clk), .rstn(rstn),
        .nv_cells(nv_cells), .nv_prog_data(nv_prog_data), .nv_prog_req(nv_prog_req),
        .nv_prog_done(nv_prog_done), .prot_init(prot_init), .prot_level(prot_level),
        .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
        .rsp(rsp), .fl_req(fl_req), .fl_op(fl_op), .fl_blk(fl_blk), .fl_data(fl_data),
        .fl_done(fl_done), .fl_ok(fl_ok), .test_pin(test_pin), .jtag_en(jtag_en),
        .swd_en(swd_en), .debug_en(debug_en), .test_en(test_en), .locked(locked));

    cell_model u_cells (.clk(clk), .rstn(rstn), .nv_prog_data(nv_prog_data),
        .nv_prog_req(nv_prog_req), .nv_cells(nv_cells), .nv_prog_done(nv_prog_done),
        .fl_req(fl_req), .fl_done(fl_done), .fl_ok(fl_ok), .lat(lat), .fail(fail),
        .preset(preset), .preset_val(preset_val));

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Hang guard, well above the longest expected run
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_fail++;
            close_out();
        end
    end

    // Answers come back in order, so the oldest note belongs to this one
    always @(negedge clk)
        if (rsp_valid === 1'b1)
        begin
            if (q.size() == 0)
                chk("unexpected answer", 32'h0, 32'h1);
            else
            begin
                nt = q.pop_front();
                chk("status", 32'(nt.st), 32'(rsp.status));
                if (nt.ck)
                    chk("data", nt.d, rsp.data);
            end
        end

    // Valid stays up on return so immediate commands can run back to back
    task automatic send(input cmd_op_t op, input dbg_port_t pt, input logic [3:0] blk,
        input logic [1:0] lv, input logic [31:0] d, input rsp_status_t st, input bit ck);
        int n;
        cmd_valid = 1;
        cmd = '{op, pt, blk, lv, d};
        n = 0;
        while (cmd_ready !== 1'b1 && n < 300)
        begin
            @(negedge clk);
            n++;
        end
        if (n == 300)
            chk("ready wait", 32'h0, 32'h1);
        q.push_back('{st, d, ck});
        @(negedge clk);
        if (fl_req === 1'b1)
            chk("flash cmd", {op, blk}, {fl_op, fl_blk});
    endtask

    task automatic drain;
        int n;
        cmd_valid = 0;
        n = 0;
        while ((q.size() != 0 || cmd_ready !== 1'b1) && n < 300)
        begin
            @(negedge clk);
            n++;
        end
        if (n == 300)
            chk("drain wait", 32'h0, 32'h1);
        @(negedge clk);
    endtask

    task automatic load_cells(input logic [31:0] v);
        preset_val = v;
        preset = 1;
        @(negedge clk);
        preset = 0;
    endtask

    task automatic do_reset;
        cmd_valid = 0;
        rstn = 0;
        @(negedge clk);
        chk("locked in reset", 32'h1, 32'(locked));
        chk("ports in reset", 32'h0, {29'h0, jtag_en, swd_en, debug_en});
        @(negedge clk);
        rstn = 1;
        repeat (3) @(negedge clk);
    endtask

    initial
    begin
        int bi, r;
        bit ok;
        logic [31:0] m;
        for (int b = 0; b < NB; b++)
            prot_init[b] = (b < 4) ? 2'(b) : 2'($random(seed));
        repeat (2) @(negedge clk);
        rstn = 1;
        preset = 0;
        test_pin = 1;
        repeat (6) @(negedge clk);
        chk("unlocked", 32'h0, 32'(locked));
        chk("ports open", 32'h7, {29'h0, jtag_en, swd_en, debug_en});
        chk("test mode", 32'h1, 32'(test_en));
        chk("levels loaded", 32'(prot_init), 32'(prot_level));
        send(OP_READ_LATCH, PORT_SWD, 4'h0, 2'h0, ~KEY, RSP_OK, 1);
        send(OP_READ_LATCH, PORT_JTAG, 4'h0, 2'h0, 32'h0, RSP_REJECT, 0);
        // Blocks 0..3 carry levels 0..3; the last index lies past the array
        for (int o = 0; o < 3; o++)
            for (int b = 0; b < 5; b++)
            begin
                bi = (b == 4) ? NB + 2 : b;
                ok = (b < 4) && ((o == 2) ? (b <= 1) : (b == 0));
                lat = 4'($random(seed));
                send(cmd_op_t'(OP_ERASE_BLK + o), PORT_JTAG, 4'(bi), 2'h0, 32'h0,
                    ok ? RSP_OK : RSP_REJECT, 0);
            end
        send(OP_SET_PROT, PORT_SWD, 4'h0, 2'h2, 32'h0, RSP_OK, 0);
        send(OP_SET_PROT, PORT_SWD, 4'h0, 2'h1, 32'h0, RSP_REJECT, 0);
        send(OP_LOAD_KEY, PORT_SWD, 4'h0, 2'h0, KEY, RSP_REJECT, 0);
        drain();
        chk("raised level", 32'h2, 32'(prot_level[0]));
        for (int p = 0; p < 2; p++)
            for (int o = 0; o < 2; o++)
                send(cmd_op_t'(OP_PROG_ALL + o), dbg_port_t'(p), 4'h0, 2'h0, 32'h0,
                    RSP_OK, 0);
        // Let the last verify finish before the engine is told to fail
        drain();
        fail = 1;
        send(OP_ERASE_ALL, PORT_JTAG, 4'h0, 2'h0, 32'h0, RSP_FAIL, 0);
        drain();
        fail = 0;
        chk("level kept", 32'h2, 32'(prot_level[0]));
        send(OP_ERASE_ALL, PORT_SWD, 4'h0, 2'h0, 32'h0, RSP_OK, 0);
        drain();
        chk("levels cleared", 32'h0, 32'(prot_level));
        // Live cells already match the key: no commit, no change of access
        load_cells(KEY);
        send(OP_COMMIT_KEY, PORT_SWD, 4'h0, 2'h0, KEY, RSP_REJECT, 0);
        drain();
        chk("lock held", 32'h0, 32'(locked));
        load_cells(~KEY);
        send(OP_LOAD_KEY, PORT_JTAG, 4'h0, 2'h0, KEY, RSP_OK, 0);
        send(OP_COMMIT_KEY, PORT_JTAG, 4'h0, 2'h0, KEY, RSP_OK, 1);
        send(OP_SET_PROT, PORT_JTAG, 4'h1, 2'h3, 32'h0, RSP_OK, 0);
        drain();
        chk("cells hold key", KEY, nv_cells);
        chk("still open", 32'h0, 32'(locked));
        do_reset();
        chk("locked after reset", 32'h1, 32'(locked));
        chk("ports closed", 32'h0, {29'h0, jtag_en, swd_en, debug_en});
        chk("test shut", 32'h0, 32'(test_en));
        send(OP_ERASE_ALL, PORT_JTAG, 4'h0, 2'h0, 32'h0, RSP_REJECT, 0);
        send(OP_COMMIT_KEY, PORT_SWD, 4'h0, 2'h0, KEY, RSP_REJECT, 0);
        send(OP_READ_LATCH, PORT_SWD, 4'h0, 2'h0, KEY, RSP_OK, 1);
        drain();
        // Four flipped bits still lock, five do not; a stride of 7 keeps them apart
        for (int k = 4; k < 6; k++)
        begin
            r = {$random(seed)} % 32;
            m = '0;
            for (int i = 0; i < k; i++)
                m[(r + 7 * i) % 32] = 1'b1;
            load_cells(KEY ^ m);
            do_reset();
            chk("vote", (k == 4) ? 32'h1 : 32'h0, 32'(locked));
        end
        drain();
        close_out();
    end
endmodule
`default_nettype wire
